// File: rtl/pbepm_defs.svh
// offsets, field positions and constant values for the bridge error and power management registers
`ifndef PBEPM_DEFS_SVH
`define PBEPM_DEFS_SVH
`define PBEPM_OFF_SYND_HI 8'h00
`define PBEPM_OFF_ERR_ADDR 8'h04
`define PBEPM_OFF_CAP_ID 8'h08
`define PBEPM_OFF_NEXT_PTR 8'h0C
`define PBEPM_OFF_PM_CAPS 8'h10
`define PBEPM_OFF_PM_CSR 8'h14
`define PBEPM_OFF_BRIDGE_EXT 8'h18
`define PBEPM_OFF_OPER_DATA 8'h1C
`define PBEPM_OFF_SC_REQ 8'h20
`define PBEPM_CAP_ID_VAL 8'h01
`define PBEPM_NEXT_PTR_VAL 8'h00
`define PBEPM_PM_CAPS_VAL 16'h0202
`define PBEPM_ET_NONE 3'h0
`define PBEPM_ET_PARITY 3'h1
`define PBEPM_ET_ABORT 3'h5
`define PBEPM_M5_ET_LSB 23
`define PBEPM_M5_DIR_BIT 22
`define PBEPM_M5_FL_BIT 21
`define PBEPM_M5_AL_BIT 20
`define PBEPM_SC_APW_BIT 4
`define PBEPM_SC_SCR_BIT 3
`define PBEPM_SC_REQ_LSB 1
`define PBEPM_PS_D2 2'h2
`endif

// File: rtl/pbepm_pkg.sv
// types for the bridge error and power management registers
package pbepm_pkg;
	typedef enum logic [1:0] {PBEPM_D0 = 2'h0, PBEPM_D1 = 2'h1, PBEPM_D2 = 2'h2, PBEPM_D3 = 2'h3} pbepm_pstate_e;
	typedef enum logic [1:0] {PBEPM_ST_IDLE = 2'b01, PBEPM_ST_PEND = 2'b10} pbepm_req_e;
endpackage

// File: rtl/pbepm_regs.sv
// bridge local bus error capture and pci power management capability registers
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "pbepm_defs.svh"
module pbepm_regs
	import pbepm_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// software register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// local bus slave error reporting for master five
	input wire logic slave_master_error,
	input wire logic err_is_parity,
	input wire logic err_is_read,
	input wire logic lock_error,
	input wire logic [31:0] err_address,
	// host configuration write to control/status
	input wire logic host_csr_wr,
	input wire logic [1:0] host_csr_pstate,
	output logic host_csr_retry,
	output logic host_csr_done,
	// processor notification and current state
	output logic pm_state_change_irq,
	output logic [1:0] power_state
);
	logic [2:0] et_q, et_d;
	logic dir_q, dir_d, fl_q, fl_d, al_q, al_d;
	logic [31:0] ear_q, ear_d;
	logic [1:0] ps_q, ps_d, req_q, req_d;
	logic apw_q, apw_d, scr_q, scr_d;
	pbepm_req_e st_q, st_d;
	logic [31:0] rdata_q, rdata_d;
	wire logic wr_synd = reg_wr && (reg_addr == `PBEPM_OFF_SYND_HI);
	wire logic wr_sc = reg_wr && (reg_addr == `PBEPM_OFF_SC_REQ);
	// recording is allowed only while unlocked
	wire logic rec_err = slave_master_error && !fl_q;
	wire logic [2:0] new_et = err_is_parity ? `PBEPM_ET_PARITY : `PBEPM_ET_ABORT;
	wire logic [31:0] synd_rd = {6'h00, et_q, dir_q, fl_q, al_q, 20'h00000};
	wire logic [15:0] csr_rd = {8'h00, 6'h00, ps_q};
	wire logic [31:0] sc_rd = {27'h0, apw_q, scr_q, req_q, 1'b0};
	// D2 is not supported by this bridge
	function automatic logic ps_ok(input logic [1:0] p);
		ps_ok = (p != `PBEPM_PS_D2);
	endfunction

	always_comb
	begin
		et_d = et_q;
		dir_d = dir_q;
		fl_d = fl_q;
		al_d = al_q;
		ear_d = ear_q;
		// write one clears fields, before capture so set wins
		if (wr_synd)
		begin
			if (|reg_wdata[25:23]) et_d = `PBEPM_ET_NONE;
			if (reg_wdata[`PBEPM_M5_DIR_BIT]) dir_d = 1'b0;
			if (reg_wdata[`PBEPM_M5_FL_BIT]) fl_d = 1'b0;
			if (reg_wdata[`PBEPM_M5_AL_BIT]) al_d = 1'b0;
		end
		// capture type, direction, locks and address
		if (rec_err)
		begin
			et_d = new_et;
			dir_d = err_is_read;
			if (lock_error) fl_d = 1'b1;
			if (!al_q) ear_d = err_address;
			if (lock_error) al_d = 1'b1;
		end
	end

	// host write handshake with local processor
	always_comb
	begin
		st_d = st_q;
		ps_d = ps_q;
		req_d = req_q;
		scr_d = scr_q;
		apw_d = apw_q;
		host_csr_retry = 1'b0;
		host_csr_done = 1'b0;
		if (wr_sc)
		begin
			scr_d = reg_wdata[`PBEPM_SC_SCR_BIT];
			apw_d = reg_wdata[`PBEPM_SC_APW_BIT];
		end
		case (st_q)
			PBEPM_ST_IDLE:
			begin
				if (host_csr_wr)
				begin
					host_csr_retry = 1'b1;
					req_d = host_csr_pstate;
					scr_d = 1'b1;
					st_d = PBEPM_ST_PEND;
				end
			end
			PBEPM_ST_PEND:
			begin
				if (host_csr_wr && apw_q)
				begin
					host_csr_done = 1'b1;
					apw_d = 1'b0;
					if (ps_ok(req_q)) ps_d = req_q;
					st_d = PBEPM_ST_IDLE;
				end
				else if (host_csr_wr)
					host_csr_retry = 1'b1;
			end
			default: st_d = PBEPM_ST_IDLE;
		endcase
	end

	always_comb
	begin
		rdata_d = 32'h00000000;
		if (reg_addr == `PBEPM_OFF_SYND_HI) rdata_d = synd_rd;
		else if (reg_addr == `PBEPM_OFF_ERR_ADDR) rdata_d = ear_q;
		else if (reg_addr == `PBEPM_OFF_CAP_ID) rdata_d = {24'h0, `PBEPM_CAP_ID_VAL};
		else if (reg_addr == `PBEPM_OFF_NEXT_PTR) rdata_d = {24'h0, `PBEPM_NEXT_PTR_VAL};
		else if (reg_addr == `PBEPM_OFF_PM_CAPS) rdata_d = {16'h0, `PBEPM_PM_CAPS_VAL};
		else if (reg_addr == `PBEPM_OFF_PM_CSR) rdata_d = {16'h0, csr_rd};
		else if (reg_addr == `PBEPM_OFF_SC_REQ) rdata_d = sc_rd;
		if (!reg_rd) rdata_d = 32'h00000000;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			et_q <= 3'h0;
			dir_q <= 1'b0;
			fl_q <= 1'b0;
			al_q <= 1'b0;
			ear_q <= 32'h00000000;
			ps_q <= 2'h0;
			req_q <= 2'h0;
			apw_q <= 1'b0;
			scr_q <= 1'b0;
			st_q <= PBEPM_ST_IDLE;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			et_q <= et_d;
			dir_q <= dir_d;
			fl_q <= fl_d;
			al_q <= al_d;
			ear_q <= ear_d;
			ps_q <= ps_d;
			req_q <= req_d;
			apw_q <= apw_d;
			scr_q <= scr_d;
			st_q <= st_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign pm_state_change_irq = scr_q;
	assign power_state = ps_q;

	// read and handshake steps shared by the checks below
	sequence s_synd_read;
		reg_rd && reg_addr == `PBEPM_OFF_SYND_HI;
	endsequence
	sequence s_caps_read;
		reg_rd && reg_addr == `PBEPM_OFF_PM_CAPS;
	endsequence
	sequence s_csr_read;
		reg_rd && reg_addr == `PBEPM_OFF_PM_CSR;
	endsequence
	sequence s_req_raised;
		host_csr_wr && st_q == PBEPM_ST_IDLE;
	endsequence
	sequence s_accept;
		host_csr_wr && st_q == PBEPM_ST_PEND && apw_q;
	endsequence

	a_lock_blocks_err: assert property (@(posedge ref_clk) disable iff (rst)
		fl_q && !wr_synd |=> $stable(et_q))
		else $error("locked syndrome changed");

	a_lock_sets: assert property (@(posedge ref_clk) disable iff (rst)
		slave_master_error && !fl_q && lock_error |=> fl_q && al_q)
		else $error("lock not set");

	a_unlock_records: assert property (@(posedge ref_clk) disable iff (rst)
		slave_master_error && !fl_q && !lock_error |=> !fl_q && et_q == $past(new_et) && dir_q == $past(err_is_read))
		else $error("unlocked error not recorded");

	a_w1c_clears: assert property (@(posedge ref_clk) disable iff (rst)
		wr_synd && reg_wdata[21] && !slave_master_error |=> !fl_q)
		else $error("field lock not cleared");

	a_lock_hold_hw: assert property (@(posedge ref_clk) disable iff (rst)
		fl_q && !wr_synd |=> fl_q)
		else $error("lock cleared by hardware");

	a_synd_resv: assert property (@(posedge ref_clk) disable iff (rst)
		s_synd_read |=> reg_rdata[31:26] == 6'h00 && reg_rdata[19:0] == 20'h00000)
		else $error("syndrome reserved bits nonzero");

	a_synd_layout: assert property (@(posedge ref_clk) disable iff (rst)
		s_synd_read |=> reg_rdata[25:20] == {$past(et_q), $past(dir_q), $past(fl_q), $past(al_q)})
		else $error("syndrome fields misplaced");

	a_et_codes: assert property (@(posedge ref_clk) disable iff (rst)
		et_q == `PBEPM_ET_NONE || et_q == `PBEPM_ET_PARITY || et_q == `PBEPM_ET_ABORT)
		else $error("reserved error type held");

	a_ear_capture: assert property (@(posedge ref_clk) disable iff (rst)
		rec_err && !al_q |=> ear_q == $past(err_address))
		else $error("address not captured");

	a_ear_read: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == `PBEPM_OFF_ERR_ADDR |=> reg_rdata == $past(ear_q))
		else $error("error address misread");

	a_ear_ro: assert property (@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == `PBEPM_OFF_ERR_ADDR && !rec_err |=> $stable(ear_q))
		else $error("error address written");

	a_capid_read: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == `PBEPM_OFF_CAP_ID |=> reg_rdata == 32'h00000001)
		else $error("bad capability id");

	a_next_ptr: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == `PBEPM_OFF_NEXT_PTR |=> reg_rdata == 32'h00000000)
		else $error("next pointer nonzero");

	a_caps_read: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == `PBEPM_OFF_PM_CAPS |=> reg_rdata == 32'h00000202)
		else $error("bad capabilities");

	a_caps_wake: assert property (@(posedge ref_clk) disable iff (rst)
		s_caps_read |=> reg_rdata[15:11] == 5'h00)
		else $error("wake support bits set");

	a_caps_dstates: assert property (@(posedge ref_clk) disable iff (rst)
		s_caps_read |=> !reg_rdata[10] && reg_rdata[9])
		else $error("state support bits wrong");

	a_caps_aux: assert property (@(posedge ref_clk) disable iff (rst)
		s_caps_read |=> reg_rdata[8:6] == 3'h0)
		else $error("aux current bits set");

	a_caps_init: assert property (@(posedge ref_clk) disable iff (rst)
		s_caps_read |=> !reg_rdata[5])
		else $error("init bit set");

	a_caps_wclk: assert property (@(posedge ref_clk) disable iff (rst)
		s_caps_read |=> !reg_rdata[3])
		else $error("wake clock bit set");

	a_caps_version: assert property (@(posedge ref_clk) disable iff (rst)
		s_caps_read |=> reg_rdata[2:0] == 3'h2)
		else $error("bad version field");

	a_csr_fixed: assert property (@(posedge ref_clk) disable iff (rst)
		s_csr_read |=> reg_rdata[15:8] == 8'h00)
		else $error("csr upper byte nonzero");

	a_csr_resv: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == `PBEPM_OFF_PM_CSR |=> reg_rdata[31:2] == 30'h0)
		else $error("csr reserved nonzero");

	a_csr_pstate: assert property (@(posedge ref_clk) disable iff (rst)
		s_csr_read |=> reg_rdata[1:0] == $past(power_state))
		else $error("power state misread");

	a_ps_take: assert property (@(posedge ref_clk) disable iff (rst)
		host_csr_done && req_q != `PBEPM_PS_D2 |=> power_state == $past(req_q))
		else $error("accepted state not taken");

	a_no_d2: assert property (@(posedge ref_clk) disable iff (rst)
		power_state != 2'h2)
		else $error("unsupported state taken");

	a_ps_keep: assert property (@(posedge ref_clk) disable iff (rst)
		host_csr_done && req_q == `PBEPM_PS_D2 |=> $stable(power_state))
		else $error("state changed on unsupported write");

	a_req_record: assert property (@(posedge ref_clk) disable iff (rst)
		s_req_raised |=> req_q == $past(host_csr_pstate))
		else $error("requested state not recorded");

	a_bridge_ext: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == `PBEPM_OFF_BRIDGE_EXT |=> reg_rdata == 32'h00000000)
		else $error("bridge extensions nonzero");

	a_oper_data: assert property (@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == `PBEPM_OFF_OPER_DATA |=> reg_rdata == 32'h00000000)
		else $error("operating data nonzero");

	a_req_retry: assert property (@(posedge ref_clk) disable iff (rst)
		s_req_raised |-> host_csr_retry ##1 pm_state_change_irq)
		else $error("request not flagged");

	a_req_pend: assert property (@(posedge ref_clk) disable iff (rst)
		s_req_raised |=> st_q == PBEPM_ST_PEND)
		else $error("request not pending");

	a_retry_until_apw: assert property (@(posedge ref_clk) disable iff (rst)
		host_csr_wr && st_q == PBEPM_ST_PEND && !apw_q |-> host_csr_retry && !host_csr_done)
		else $error("write not retried");

	a_accept_clears: assert property (@(posedge ref_clk) disable iff (rst)
		s_accept |-> host_csr_done ##1 (!apw_q && st_q == PBEPM_ST_IDLE))
		else $error("acceptance not completed");
endmodule // pbepm_regs

// File: verif/pbepm_host_model.sv
// pci host model issuing control/status writes
`timescale 1ns/1ps
module pbepm_host_model
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// request from the bench
	input wire logic start,
	input wire logic [1:0] target,
	output logic busy,
	// config write port
	input wire logic host_csr_retry,
	input wire logic host_csr_done,
	output logic host_csr_wr,
	output logic [1:0] host_csr_pstate
);
	logic [1:0] gap_q;
	always_ff @(posedge ref_clk)
	begin
		if (rst || (host_csr_wr && host_csr_done))
		begin
			busy <= 1'b0;
			host_csr_wr <= 1'b0;
			gap_q <= 2'h0;
		end
		else
		begin
			busy <= busy | start;
			gap_q <= host_csr_retry ? 2'h1 : gap_q + 2'h1;
			host_csr_wr <= (busy | start) & (gap_q == 2'h0) & ~host_csr_wr;
		end
		// data lines toggle while idle so nothing stale is read
		host_csr_pstate <= rst ? 2'h0 : (busy | start) ? target : ~host_csr_pstate;
	end
endmodule // pbepm_host_model

// File: verif/pbepm_regs_tb.sv
// self-checking bench for the bridge error and power management registers
`timescale 1ns/1ps
`include "pbepm_defs.svh"
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module pbepm_regs_tb;
	import pbepm_pkg::*;
	logic ref_clk, rst, reg_wr, reg_rd, sme, par, rdir, lck, csr_wr, retry, done, irq, start, busy;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, rdata, eaddr, v;
	logic [1:0] cps, pstate, tgt;
	int n_errors = 0;
	int total_checks = 0;
	int n_retry = 0;
	int n_done = 0;
	localparam logic [39:0] ROWS [9] = '{{`PBEPM_OFF_SYND_HI, 32'h0}, {`PBEPM_OFF_ERR_ADDR, 32'h0},
		{`PBEPM_OFF_CAP_ID, 32'h1}, {`PBEPM_OFF_NEXT_PTR, 32'h0}, {`PBEPM_OFF_PM_CAPS, 32'h202},
		{`PBEPM_OFF_PM_CSR, 32'h0}, {`PBEPM_OFF_BRIDGE_EXT, 32'h0}, {`PBEPM_OFF_OPER_DATA, 32'h0}, {8'hFC, 32'h0}};
	pbepm_regs dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(rdata), .slave_master_error(sme), .err_is_parity(par), .err_is_read(rdir),
		.lock_error(lck), .err_address(eaddr), .host_csr_wr(csr_wr), .host_csr_pstate(cps),
		.host_csr_retry(retry), .host_csr_done(done), .pm_state_change_irq(irq), .power_state(pstate));
	pbepm_host_model host_u (.ref_clk(ref_clk), .rst(rst), .start(start), .target(tgt), .busy(busy),
		.host_csr_retry(retry), .host_csr_done(done), .host_csr_wr(csr_wr), .host_csr_pstate(cps));
	always @(posedge ref_clk)
	begin
		if (retry === 1'b1) n_retry++;
		if (done === 1'b1) n_done++;
	end
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		v = rdata;
	endtask
	task automatic err(input logic p, input logic r, input logic l, input logic [31:0] a);
		@(posedge ref_clk);
		sme <= 1'b1; par <= p; rdir <= r; lck <= l; eaddr <= a;
		@(posedge ref_clk);
		sme <= 1'b0; eaddr <= ~a;
	endtask
	// host asks for state t, processor accepts, state e expected
	task automatic pm_req(input logic [1:0] t, input logic [1:0] e);
		int n, r0, d0;
		r0 = n_retry;
		d0 = n_done;
		tgt <= t; start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		for (n = 0; n < 60 && irq !== 1'b1; n++) @(posedge ref_clk);
		`CHK("irq", 1'b1, irq)
		if (irq !== 1'b1) summarize();
		wr(`PBEPM_OFF_SC_REQ, 32'h10);
		for (n = 0; n < 60 && busy !== 1'b0; n++) @(posedge ref_clk);
		`CHK("host busy", 1'b0, busy)
		if (busy !== 1'b0) summarize();
		`CHK("retried", 1'b1, n_retry > r0)
		`CHK("accepted", d0 + 1, n_done)
		rd(`PBEPM_OFF_PM_CSR);
		`CHK("csr", {30'h0, e}, v)
		`CHK("pstate", e, pstate)
	endtask
	initial
	begin
		{rst, reg_wr, reg_rd, sme, par, rdir, lck, start} = 8'hFF;
		{reg_wr, reg_rd, sme, par, rdir, lck, start, tgt, reg_addr, reg_wdata, eaddr} = '0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			rd(ROWS[i][39:32]);
			`CHK("table", ROWS[i][31:0], v)
		end
		$display("test table done");
		err(1'b1, 1'b1, 1'b1, 32'hA5A5_0F0F);
		err(1'b0, 1'b0, 1'b0, 32'h1234_5678);
		rd(`PBEPM_OFF_SYND_HI);
		`CHK("synd lock", 32'h00F0_0000, v)
		rd(`PBEPM_OFF_ERR_ADDR);
		`CHK("addr", 32'hA5A5_0F0F, v)
		wr(`PBEPM_OFF_ERR_ADDR, 32'hFFFF_FFFF);
		rd(`PBEPM_OFF_ERR_ADDR);
		`CHK("addr ro", 32'hA5A5_0F0F, v)
		wr(`PBEPM_OFF_SYND_HI, 32'hFFCF_FFFF);
		rd(`PBEPM_OFF_SYND_HI);
		`CHK("synd w1c", 32'h0030_0000, v)
		wr(`PBEPM_OFF_SYND_HI, 32'h0030_0000);
		err(1'b0, 1'b0, 1'b0, 32'h5A5A_F0F0);
		rd(`PBEPM_OFF_SYND_HI);
		`CHK("synd abort", 32'h0280_0000, v)
		rd(`PBEPM_OFF_ERR_ADDR);
		`CHK("addr2", 32'h5A5A_F0F0, v)
		$display("test error capture done");
		pm_req(2'h1, 2'h1);
		pm_req(2'h2, 2'h1);
		rd(`PBEPM_OFF_SC_REQ);
		`CHK("req state", 32'h4, v)
		pm_req(2'h3, 2'h3);
		$display("test power state done");
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`PBEPM_OFF_PM_CSR);
		`CHK("csr reset", 32'h0, v)
		`CHK("irq reset", 1'b0, irq)
		rd(`PBEPM_OFF_SYND_HI);
		`CHK("synd reset", 32'h0, v)
		pm_req(2'h0, 2'h0);
		wr(`PBEPM_OFF_SC_REQ, 32'h8);
		rd(`PBEPM_OFF_SC_REQ);
		`CHK("scr set", 32'h8, v)
		`CHK("irq sw", 1'b1, irq)
		$display("test reset and request flag done");
		summarize();
	end
endmodule // pbepm_regs_tb
